// ===== hdl/csr_top.sv
/*
 * CPU special registers: main, helper, stack, dual data pointers, status, port 2.
 * Assumes a one-cycle register port master that never issues read and write together.
 */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module csr_top (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [2:0] alu_op_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic dp_inc_i,
    input wire logic xdata_start_i,
    input wire logic [7:0] port2_in_i,
    output logic [7:0] port2_out_o,
    output logic [7:0] port2_oe_n_o,
    output logic ram_we_o,
    output logic [10:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic [23:0] data_pointer_o,
    output logic [1:0] bank_sel_o,
    output logic [4:0] bank_base_o
);
    logic [7:0] main_arith_reg;
    logic [7:0] mul_div_helper;
    logic [7:0] cpu_status_flags;
    logic [7:0] port2_latch;
    logic dp_sel;
    logic [7:0] pointer_page_byte [csr_pkg::DP_COUNT];
    logic [7:0] pointer_high_byte [csr_pkg::DP_COUNT];
    logic [7:0] pointer_low_byte [csr_pkg::DP_COUNT];
    logic [7:0] p2_s1, p2_s2, p2_s3, p2_stable;
    csr_pkg::csr_xphase_t xphase;
    csr_pkg::csr_alu_op_t op;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic [15:0] product;
    logic [23:0] cur_dp;
    logic [23:0] next_dp;
    csr_stack_if st();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign op = csr_pkg::csr_alu_op_t'(alu_op_i);
    assign cur_dp = {pointer_page_byte[dp_sel], pointer_high_byte[dp_sel],
        pointer_low_byte[dp_sel]};
    assign next_dp = cur_dp + 24'h000001;
    assign product = {8'h00, main_arith_reg} * {8'h00, mul_div_helper};
    assign sum9 = (op == csr_pkg::CSR_OP_SUB)
        ? {1'b0, main_arith_reg} - {1'b0, mul_div_helper} - {8'h00, cpu_status_flags[7]}
        : {1'b0, main_arith_reg} + {1'b0, mul_div_helper};
    assign half5 = (op == csr_pkg::CSR_OP_SUB)
        ? {1'b0, main_arith_reg[3:0]} - {1'b0, mul_div_helper[3:0]}
            - {4'h0, cpu_status_flags[7]}
        : {1'b0, main_arith_reg[3:0]} + {1'b0, mul_div_helper[3:0]};

    csr_stack u_stack (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .st(st)
    );
    assign st.push = push_i;
    assign st.wr_low = reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_SP_LOW);
    assign st.wr_ext = reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_SP_EXT);
    assign st.wdata = reg_wdata_i;

    // ============================================================
    // Main and helper registers
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            main_arith_reg <= csr_pkg::RST_ZERO;
            mul_div_helper <= csr_pkg::RST_ZERO;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_MAIN)) begin
            main_arith_reg <= reg_wdata_i;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_HELPER)) begin
            mul_div_helper <= reg_wdata_i;
        end else begin
            case (op)
                csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_SUB: begin
                    main_arith_reg <= sum9[7:0];
                end
                csr_pkg::CSR_OP_MUL: begin
                    main_arith_reg <= product[7:0];
                    mul_div_helper <= product[15:8];
                end
                csr_pkg::CSR_OP_DIV: begin
                    if (mul_div_helper != 8'h00) begin
                        main_arith_reg <= main_arith_reg / mul_div_helper;
                        mul_div_helper <= main_arith_reg % mul_div_helper;
                    end
                end
                csr_pkg::CSR_OP_AND: main_arith_reg <= main_arith_reg & mul_div_helper;
                csr_pkg::CSR_OP_OR: main_arith_reg <= main_arith_reg | mul_div_helper;
                csr_pkg::CSR_OP_XOR: main_arith_reg <= main_arith_reg ^ mul_div_helper;
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Status flags
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cpu_status_flags <= csr_pkg::RST_STATUS;
        end else if (op == csr_pkg::CSR_OP_ADD || op == csr_pkg::CSR_OP_SUB) begin
            cpu_status_flags[csr_pkg::BIT_CARRY] <= sum9[8];
            cpu_status_flags[csr_pkg::BIT_HALF] <= half5[4];
        end else if (op == csr_pkg::CSR_OP_MUL || op == csr_pkg::CSR_OP_DIV) begin
            cpu_status_flags[csr_pkg::BIT_CARRY] <= 1'b0;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_STATUS)) begin
            cpu_status_flags <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            bank_sel_o <= 2'h0;
            bank_base_o <= 5'h00;
        end else begin
            bank_sel_o <= cpu_status_flags[csr_pkg::BIT_BANK_HI:csr_pkg::BIT_BANK_LO];
            bank_base_o <= {cpu_status_flags[csr_pkg::BIT_BANK_HI:csr_pkg::BIT_BANK_LO],
                3'h0};
        end
    end

    // ============================================================
    // Dual data pointers
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dp_sel <= 1'b0;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_DP_SEL)) begin
            dp_sel <= reg_wdata_i[0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < csr_pkg::DP_COUNT; i++) begin
                pointer_page_byte[i] <= csr_pkg::RST_ZERO;
                pointer_high_byte[i] <= csr_pkg::RST_ZERO;
                pointer_low_byte[i] <= csr_pkg::RST_ZERO;
            end
        end else if (dp_inc_i) begin
            {pointer_page_byte[dp_sel], pointer_high_byte[dp_sel],
                pointer_low_byte[dp_sel]} <= next_dp;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_DP_PAGE)) begin
            pointer_page_byte[dp_sel] <= reg_wdata_i;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_DP_HIGH)) begin
            pointer_high_byte[dp_sel] <= reg_wdata_i;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_DP_LOW)) begin
            pointer_low_byte[dp_sel] <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            data_pointer_o <= 24'h000000;
        end else begin
            data_pointer_o <= cur_dp;
        end
    end

    // ============================================================
    // Internal RAM push port
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ram_we_o <= 1'b0;
            ram_addr_o <= 11'h000;
            ram_wdata_o <= 8'h00;
        end else begin
            ram_we_o <= push_i;
            ram_addr_o <= st.push_addr;
            ram_wdata_o <= push_data_i;
        end
    end

    // ============================================================
    // Port 2 and external address phases
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            port2_latch <= csr_pkg::RST_PORT2;
        end else if (reg_wr_i && hit(reg_addr_i, csr_pkg::OFS_PORT2)) begin
            port2_latch <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            p2_s1 <= 8'hFF;
            p2_s2 <= 8'hFF;
            p2_s3 <= 8'hFF;
            p2_stable <= 8'hFF;
        end else begin
            p2_s1 <= port2_in_i;
            p2_s2 <= p2_s1;
            p2_s3 <= p2_s2;
            for (int i = 0; i < 8; i++) begin
                if (p2_s2[i] == p2_s3[i]) begin
                    p2_stable[i] <= p2_s3[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            xphase <= csr_pkg::CSR_XP_IDLE;
        end else begin
            case (xphase)
                csr_pkg::CSR_XP_IDLE: if (xdata_start_i) xphase <= csr_pkg::CSR_XP_MID;
                csr_pkg::CSR_XP_MID: xphase <= csr_pkg::CSR_XP_HIGH;
                default: xphase <= csr_pkg::CSR_XP_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            port2_out_o <= 8'hFF;
            port2_oe_n_o <= csr_pkg::RST_PORT2;
        end else if (xphase == csr_pkg::CSR_XP_MID) begin
            port2_out_o <= cur_dp[15:8];
            port2_oe_n_o <= 8'h00;
        end else if (xphase == csr_pkg::CSR_XP_HIGH) begin
            port2_out_o <= cur_dp[23:16];
            port2_oe_n_o <= 8'h00;
        end else begin
            port2_out_o <= port2_latch;
            port2_oe_n_o <= port2_latch;
        end
    end

    // ============================================================
    // Read port
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (hit(reg_addr_i, csr_pkg::OFS_MAIN)) reg_rdata_o <= main_arith_reg;
            else if (hit(reg_addr_i, csr_pkg::OFS_HELPER)) reg_rdata_o <= mul_div_helper;
            else if (hit(reg_addr_i, csr_pkg::OFS_SP_LOW)) reg_rdata_o <= st.sp[7:0];
            else if (hit(reg_addr_i, csr_pkg::OFS_SP_EXT)) reg_rdata_o <= {5'h00, st.sp[10:8]};
            else if (hit(reg_addr_i, csr_pkg::OFS_DP_LOW)) reg_rdata_o <= cur_dp[7:0];
            else if (hit(reg_addr_i, csr_pkg::OFS_DP_HIGH)) reg_rdata_o <= cur_dp[15:8];
            else if (hit(reg_addr_i, csr_pkg::OFS_DP_PAGE)) reg_rdata_o <= cur_dp[23:16];
            else if (hit(reg_addr_i, csr_pkg::OFS_DP_SEL)) reg_rdata_o <= {7'h00, dp_sel};
            else if (hit(reg_addr_i, csr_pkg::OFS_STATUS)) reg_rdata_o <= cpu_status_flags;
            else if (hit(reg_addr_i, csr_pkg::OFS_PORT2)) reg_rdata_o <= p2_stable;
            else reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ============================================================
    // Checks
    sequence s_mid_phase;
        xphase == csr_pkg::CSR_XP_MID;
    endsequence
    a_dp_carry: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        dp_inc_i && cur_dp[15:0] == 16'hFFFF |=>
        pointer_page_byte[$past(dp_sel)] == $past(cur_dp[23:16]) + 8'h01)
        else $error("page carry lost");
    a_ram_after_push: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        push_i |=> ram_we_o && ram_addr_o == st.sp) else $error("push address wrong");
    a_p2_addr_order: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        xphase == csr_pkg::CSR_XP_IDLE && xdata_start_i |=> s_mid_phase ##1
        port2_out_o == $past(cur_dp[15:8]) ##1 port2_out_o == $past(cur_dp[23:16]))
        else $error("port 2 address phase wrong");
    a_mul_result: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        op == csr_pkg::CSR_OP_MUL && !reg_wr_i |=>
        {mul_div_helper, main_arith_reg} == $past(product)) else $error("bad product");
    a_add_carry: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        op == csr_pkg::CSR_OP_ADD |=> cpu_status_flags[7] == $past(sum9[8]))
        else $error("carry flag wrong");
    a_bank_follow: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        1'b1 |=> bank_sel_o == $past(cpu_status_flags[4:3])) else $error("bank wrong");
    a_read_latency: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == csr_pkg::OFS_DP_SEL |=> reg_rdata_o == {7'h00, dp_sel})
        else $error("select read wrong");
    a_p2_release: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        xphase == csr_pkg::CSR_XP_IDLE && !xdata_start_i ##1 xphase == csr_pkg::CSR_XP_IDLE
        |-> port2_oe_n_o == $past(port2_latch)) else $error("pin release wrong");
    a_pointer_out: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        1'b1 |=> data_pointer_o == $past(cur_dp)) else $error("pointer output wrong");
    a_div_result: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        op == csr_pkg::CSR_OP_DIV && !reg_wr_i && mul_div_helper != 8'h00 |=>
        main_arith_reg == $past(main_arith_reg) / $past(mul_div_helper))
        else $error("bad quotient");
    a_p2_drive_mid: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_mid_phase |=> port2_oe_n_o == 8'h00) else $error("port 2 not driven");
endmodule
`default_nettype wire

// ===== hdl/csr_pkg.sv
/*
 * Constants, offsets and reset values for the CPU special register block.
 * Assumes a single 50 MHz clock and a synchronous active-high reset.
 */
`default_nettype none
//==============================================================
// Operation
// - Push or call first bumps the stack pointer, then writes at new value
// - Stack pointer resets to 07H so the first push lands at 08H
// - Stack pointer is 11 bits; upper three from extension byte low bits
// - Pointer is page, high, low bytes; increment carries into page
// - Pointer usable as one 24-bit value or three separate bytes
// - Pointer value addresses code fetch and external data accesses
// - Two data pointers are provided
// - Main register is operand and result for arithmetic and bit ops
// - Helper pairs with main register for multiply and divide
// - Status: carry bit 7, half carry 6, user flag 5, bank upper 4
// - Port 2 pins bidirectional with pull-up; written 1 reads as input
// - Port 2 drives middle then high address byte in external access
package csr_pkg;
    localparam logic [7:0] OFS_MAIN = 8'hE0;
    localparam logic [7:0] OFS_HELPER = 8'hF0;
    localparam logic [7:0] OFS_SP_LOW = 8'h81;
    localparam logic [7:0] OFS_SP_EXT = 8'hB7;
    localparam logic [7:0] OFS_DP_LOW = 8'h82;
    localparam logic [7:0] OFS_DP_HIGH = 8'h83;
    localparam logic [7:0] OFS_DP_PAGE = 8'h84;
    localparam logic [7:0] OFS_DP_SEL = 8'hA7;
    localparam logic [7:0] OFS_PORT2 = 8'hA0;
    localparam logic [7:0] OFS_STATUS = 8'hD0;
    localparam logic [7:0] RST_SP_LOW = 8'h07;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT2 = 8'hFF;
    localparam int BIT_CARRY = 7;
    localparam int BIT_HALF = 6;
    localparam int BIT_USER = 5;
    localparam int BIT_BANK_HI = 4;
    localparam int BIT_BANK_LO = 3;
    localparam int SP_EXT_BITS = 3;
    localparam int SP_WIDTH = 11;
    localparam int DP_COUNT = 2;
    typedef enum logic [2:0] {
        CSR_OP_NONE,
        CSR_OP_ADD,
        CSR_OP_SUB,
        CSR_OP_MUL,
        CSR_OP_DIV,
        CSR_OP_AND,
        CSR_OP_OR,
        CSR_OP_XOR
    } csr_alu_op_t;
    typedef enum logic [1:0] {
        CSR_XP_IDLE,
        CSR_XP_MID,
        CSR_XP_HIGH
    } csr_xphase_t;
endpackage
`default_nettype wire

// ===== hdl/csr_stack_if.sv
/*
 * Carrier between the stack unit and the register block.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface csr_stack_if;
    logic push;
    logic wr_low;
    logic wr_ext;
    logic [7:0] wdata;
    logic [10:0] sp;
    logic [10:0] push_addr;
    modport unit(input push, input wr_low, input wr_ext, input wdata,
        output sp, output push_addr);
    modport user(output push, output wr_low, output wr_ext, output wdata,
        input sp, input push_addr);
endinterface
`default_nettype wire

// ===== hdl/csr_stack.sv
/*
 * Eleven-bit pre-incrementing stack pointer.
 * Assumes pushes and software writes never arrive together.
 */
`timescale 1ns/1ps
`default_nettype none
module csr_stack (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    csr_stack_if.unit st
);
    logic [10:0] sp;
    logic [10:0] next_sp;
    assign next_sp = sp + 11'h001;
    assign st.sp = sp;
    assign st.push_addr = next_sp;
    // ============================================================
    // Pointer update
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp <= {3'h0, csr_pkg::RST_SP_LOW};
        end else if (st.push) begin
            sp <= next_sp;
        end else if (st.wr_low) begin
            sp[7:0] <= st.wdata;
        end else if (st.wr_ext) begin
            sp[10:8] <= st.wdata[2:0];
        end
    end
    a_push_bumps: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st.push |=> sp == $past(sp) + 11'h001) else $error("push did not bump");
    a_reset_value: assert property (@(posedge core_clk_i)
        sys_rst_i |=> sp == 11'h007) else $error("bad stack reset");
endmodule
`default_nettype wire

// ===== tb/test_cpu_core_special_registers.sv
/*
 * Self-checking bench for the CPU special register block.
 * Assumes csr_pkg, the stack carrier and the design modules are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_cpu_core_special_registers;
    //==============================================================
    // Signals
    logic core_clk_i;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [2:0] alu_op_i = 3'h0;
    logic push_i = 1'b0;
    logic [7:0] push_data_i = 8'h00;
    logic dp_inc_i = 1'b0;
    logic xdata_start_i = 1'b0;
    logic [7:0] port2_ext = 8'hFF;
    logic [7:0] reg_rdata_o, port2_out_o, port2_oe_n_o, ram_wdata_o;
    logic ram_we_o;
    logic [10:0] ram_addr_o;
    logic [23:0] data_pointer_o;
    logic [1:0] bank_sel_o;
    logic [4:0] bank_base_o;
    int fail_count = 0;
    int tests_run = 0;
    // Pin level: driven where enabled, else the outside source over the pull-up
    wire logic [7:0] port2_in_i = (port2_out_o & ~port2_oe_n_o) | (port2_ext & port2_oe_n_o);

    csr_top csr_top_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .alu_op_i(alu_op_i),
        .push_i(push_i), .push_data_i(push_data_i), .dp_inc_i(dp_inc_i),
        .xdata_start_i(xdata_start_i), .port2_in_i(port2_in_i),
        .port2_out_o(port2_out_o), .port2_oe_n_o(port2_oe_n_o), .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o),
        .data_pointer_o(data_pointer_o), .bank_sel_o(bank_sel_o),
        .bank_base_o(bank_base_o));

    //==============================================================
    // Clock, verdict and watchdog
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic stop_test;
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk_i);
        fail_count++;
        stop_test;
    end

    //==============================================================
    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] ex,
        input string nm);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        `CHK(nm, ex, reg_rdata_o & m)
        @(posedge core_clk_i);
    endtask

    //==============================================================
    // Scenarios
    task automatic test_reset;
        @(negedge core_clk_i);
        `CHK("ram_we", 1'b0, ram_we_o)
        `CHK("port2_out", 8'hFF, port2_out_o)
        `CHK("port2_oe_n", 8'hFF, port2_oe_n_o)
        `CHK("pointer", 24'h000000, data_pointer_o)
        @(posedge core_clk_i);
        rdchk(csr_pkg::OFS_SP_LOW, 8'hFF, csr_pkg::RST_SP_LOW, "sp_low");
        rdchk(csr_pkg::OFS_STATUS, 8'hFF, csr_pkg::RST_STATUS, "status");
        rdchk(csr_pkg::OFS_SP_EXT, 8'hFF, 8'h00, "sp_ext");
        wr(8'h90, 8'h5A);
        rdchk(8'h90, 8'hFF, 8'h00, "unmapped");
    endtask

    task automatic test_stack;
        push_data_i <= 8'hA1;
        push_i <= 1'b1;
        @(posedge core_clk_i);
        push_data_i <= 8'hB2;
        @(negedge core_clk_i);
        `CHK("push_we", 1'b1, ram_we_o)
        `CHK("push_addr", 11'h008, ram_addr_o)
        `CHK("push_data", 8'hA1, ram_wdata_o)
        @(posedge core_clk_i);
        push_i <= 1'b0;
        @(negedge core_clk_i);
        `CHK("push_addr2", 11'h009, ram_addr_o)
        `CHK("push_data2", 8'hB2, ram_wdata_o)
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("push_we_end", 1'b0, ram_we_o)
        @(posedge core_clk_i);
        rdchk(csr_pkg::OFS_SP_LOW, 8'hFF, 8'h09, "sp_after");
        wr(csr_pkg::OFS_SP_EXT, 8'hFD);
        rdchk(csr_pkg::OFS_SP_EXT, 8'hFF, 8'h05, "sp_ext_bits");
        wr(csr_pkg::OFS_SP_LOW, 8'hFF);
        push_data_i <= 8'hC3;
        push_i <= 1'b1;
        @(posedge core_clk_i);
        push_i <= 1'b0;
        @(negedge core_clk_i);
        `CHK("push_wide", 11'h600, ram_addr_o)
        @(posedge core_clk_i);
        rdchk(csr_pkg::OFS_SP_EXT, 8'hFF, 8'h06, "sp_ext_carry");
    endtask

    task automatic test_pointer;
        wr(csr_pkg::OFS_DP_LOW, 8'hFF);
        wr(csr_pkg::OFS_DP_HIGH, 8'hFF);
        wr(csr_pkg::OFS_DP_PAGE, 8'h12);
        dp_inc_i <= 1'b1;
        @(posedge core_clk_i);
        dp_inc_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("dp_inc", 24'h130000, data_pointer_o)
        @(posedge core_clk_i);
        rdchk(csr_pkg::OFS_DP_PAGE, 8'hFF, 8'h13, "dp_page");
        rdchk(csr_pkg::OFS_DP_HIGH, 8'hFF, 8'h00, "dp_high");
        wr(csr_pkg::OFS_DP_SEL, 8'h01);
        rdchk(csr_pkg::OFS_DP_SEL, 8'hFF, 8'h01, "dp_sel");
        wr(csr_pkg::OFS_DP_LOW, 8'h55);
        @(negedge core_clk_i);
        `CHK("dp_second", 24'h000055, data_pointer_o)
        @(posedge core_clk_i);
        wr(csr_pkg::OFS_DP_SEL, 8'h00);
        @(negedge core_clk_i);
        `CHK("dp_first", 24'h130000, data_pointer_o)
        @(posedge core_clk_i);
    endtask

    task automatic test_alu;
        logic [2:0] op [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1};
        logic [7:0] ta [8] = '{8'h12, 8'h46, 8'h0C, 8'h64, 8'hF0, 8'hF0, 8'hAA, 8'hFF};
        logic [7:0] tb [8] = '{8'h34, 8'h34, 8'h0D, 8'h07, 8'h3C, 8'h0F, 8'hFF, 8'h01};
        logic [7:0] em [8] = '{8'h46, 8'h12, 8'h9C, 8'h0E, 8'h30, 8'hFF, 8'h55, 8'h00};
        logic [7:0] eh [8] = '{8'h34, 8'h34, 8'h00, 8'h02, 8'h3C, 8'h0F, 8'hFF, 8'h01};
        for (int i = 0; i < 8; i++) begin
            wr(csr_pkg::OFS_MAIN, ta[i]);
            wr(csr_pkg::OFS_HELPER, tb[i]);
            wr(csr_pkg::OFS_STATUS, 8'h00);
            alu_op_i <= op[i];
            @(posedge core_clk_i);
            alu_op_i <= 3'h0;
            @(posedge core_clk_i);
            rdchk(csr_pkg::OFS_MAIN, 8'hFF, em[i], "main");
            rdchk(csr_pkg::OFS_HELPER, 8'hFF, eh[i], "helper");
        end
        rdchk(csr_pkg::OFS_STATUS, 8'hC0, 8'hC0, "carry_half");
    endtask

    task automatic test_status;
        for (int b = 0; b < 4; b++) begin
            wr(csr_pkg::OFS_STATUS, 8'h20 | 8'(b << 3));
            @(negedge core_clk_i);
            `CHK("bank_sel", 2'(b), bank_sel_o)
            `CHK("bank_base", 5'(b * 8), bank_base_o)
            @(posedge core_clk_i);
            rdchk(csr_pkg::OFS_STATUS, 8'hF8, 8'h20 | 8'(b << 3), "status_bits");
        end
    endtask

    task automatic test_port2;
        wr(csr_pkg::OFS_PORT2, 8'h0F);
        port2_ext <= 8'hA5;
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("p2_out", 8'h0F, port2_out_o)
        `CHK("p2_oe_n", 8'h0F, port2_oe_n_o)
        @(posedge core_clk_i);
        rdchk(csr_pkg::OFS_PORT2, 8'hFF, 8'h05, "p2_pins");
        wr(csr_pkg::OFS_DP_LOW, 8'h56);
        wr(csr_pkg::OFS_DP_HIGH, 8'h34);
        wr(csr_pkg::OFS_DP_PAGE, 8'h12);
        xdata_start_i <= 1'b1;
        @(posedge core_clk_i);
        xdata_start_i <= 1'b0;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("xd_mid", 8'h34, port2_out_o)
        `CHK("xd_mid_oe", 8'h00, port2_oe_n_o)
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("xd_high", 8'h12, port2_out_o)
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("xd_idle", 8'h0F, port2_out_o)
        `CHK("xd_idle_oe", 8'h0F, port2_oe_n_o)
        @(posedge core_clk_i);
    endtask

    //==============================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        test_reset;
        test_stack;
        test_pointer;
        test_alu;
        test_status;
        test_port2;
        stop_test;
    end
endmodule
`default_nettype wire
